// file: shared/supply_ctrl_pkg.sv
// constants, carrier types and state record of the supply control block
package supply_ctrl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int COPY_TIME_NS  = 1600000;
  localparam int COPY_CYC      = COPY_TIME_NS / CLK_PERIOD_NS;
  localparam int RST_UNIT_NS   = 1000000;
  localparam int RST_UNIT_CYC  = RST_UNIT_NS / CLK_PERIOD_NS;
  localparam int CTL_MIN_NS    = 1000;
  localparam int CTL_MIN_CYC   =
    (CTL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = 4;
  localparam int COPY_W        = 17;
  localparam int CNT_W         = 24;
  localparam int CTL_W         = 12;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_RST_SEL  = 8'h00;
  localparam logic [7:0] OFS_RST_DLY  = 8'h01;
  localparam logic [7:0] OFS_OUT_MODE = 8'h02;
  localparam logic [7:0] OFS_DEV_MODE = 8'h03;
  localparam logic [7:0] OFS_FRESP    = 8'h04;
  localparam logic [7:0] OFS_ONOFF    = 8'h05;
  localparam logic [7:0] OFS_PAGE     = 8'h06;
  localparam logic [7:0] OFS_CMD      = 8'h07;
  localparam logic [7:0] OFS_ARA      = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h09;
  localparam logic [7:0] OFS_ADDR     = 8'h0a;
  localparam logic [7:0] OFS_NEW_ADDR = 8'h0b;

  // ==========================================================
  // field positions
  localparam int GLOB_LSB      = 0;
  localparam int POL_LSB       = 4;
  localparam int IGN_EN_BIT    = 0;
  localparam int FRESP_OFF_BIT = 0;
  localparam int ONOFF_CTL_BIT = 0;
  localparam int CMD_ON_BIT    = 0;
  localparam int CMD_OFF_BIT   = 1;
  localparam int CMD_CLR_BIT   = 2;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [7:0] RST_SEL_RST  = 8'h00;
  localparam logic [7:0] RST_DLY_RST  = 8'h00;
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [7:0] PAGE_ALL     = 8'hff;
  localparam logic [6:0] ADDR_ALL_LOW = 7'h40;
  localparam logic [6:0] ADDR_BCAST   = 7'h00;

  // ==========================================================
  // types
  typedef enum logic [1:0] {B_SETTLE, B_COPY, B_RUN} boot_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [3:0] pol;
  } eeprom_cfg_t;

  typedef struct packed {
    logic [2:0]       en_sync;
    logic             en_lvl;
    logic [2:0][2:0]  hi_sync;
    logic [2:0][2:0]  op_sync;
    logic [2:0]       hi_lvl;
    logic [2:0]       op_lvl;
    boot_t            boot;
    logic [COPY_W-1:0] copy_cnt;
    logic             ctl_state;
    logic [CTL_W-1:0] ctl_cnt;
    logic [7:0]       rst_sel;
    logic [7:0]       rst_dly;
    logic [7:0]       out_mode;
    logic [7:0]       dev_mode;
    logic [7:0]       fresp;
    logic [7:0]       onoff;
    logic [7:0]       page;
    logic [7:0]       new_addr;
    logic [6:0]       slave_addr;
    logic [3:0]       pol;
    logic [3:0]       ch_on;
    logic [3:0]       fault_prev;
    logic             en_fault;
    logic             alert;
    logic             rst_assert;
    logic             rst_oe_b;
    logic             alert_oe_b;
    logic [CNT_W-1:0] rst_cnt;
    logic [7:0]       rdata;
    logic [3:0]       sup_en;
    logic             hit;
    logic             pin_low;
  } ctrl_state_t;

endpackage

// file: rtl/supply_ctrl.sv
// control pins, reset and alert outputs, and address logic of the sequencer
`timescale 1ns/1ps
// ============================================================
// How it works
// - reset output held low through power-on
// - release after programmed timeout once channel good
// - select 0..3 picks channel, else low forever
// - tied channel disabled reasserts reset at once
// - global fault bits, all four set, route any fault to reset
// - any fault pulls the alert output low
// - alert response read returns address, releases alert
// - alert released when faults clear or cleared
// - enables low at power-up, high on command
// - polarity bit one makes enable active low
// - configuration copy takes about 1.6 ms
// - enable input low blocks turn-on unless ignored
// - enable falling while on runs fault action
// - three-level address pins map to slave address
// - broadcast address also answered
// - valid stored address overrides pins unless bit7
// - new address only stored, never applied to the slave address
// - third address pin becomes control after detect
// - control rising edge acts as turn-on command
// - control falling edge acts as soft-off command
// - commands still obeyed, control pulses need widths
// - page selects channel for channel commands
module supply_ctrl #(
  parameter int COPY_CYC     = supply_ctrl_pkg::COPY_CYC,
  parameter int RST_UNIT_CYC = supply_ctrl_pkg::RST_UNIT_CYC,
  parameter int CTL_MIN_CYC  = supply_ctrl_pkg::CTL_MIN_CYC
) (
  input  wire logic                   mclk_in,          // 40 MHz clock
  input  wire logic                   rst_b_in,         // async reset
  input  wire supply_ctrl_pkg::reg_req_t reg_req_in,    // register request
  output logic [7:0]                  reg_rdata_out,    // read data
  input  wire logic [3:0]             pgood_in,         // channel at target
  input  wire logic [3:0]             fault_in,         // channel fault
  input  wire logic                   en_pin_in,        // enable pin
  input  wire logic [2:0]             addr_pin_high_in, // pin reads high
  input  wire logic [2:0]             addr_pin_open_in, // pin reads open
  input  wire supply_ctrl_pkg::eeprom_cfg_t eeprom_in,  // copied config
  input  wire logic [6:0]             bus_addr_in,      // framed address
  output logic                        addr_hit_out,     // address match
  output logic [3:0]                  supply_enable_out, // supply enables
  output logic                        reset_pin_out,    // reset pin level
  output logic                        reset_oe_b_out,   // reset pull-low
  output logic                        alert_pin_out,    // alert pin level
  output logic                        alert_oe_b_out    // alert pull-low
);

  // ==========================================================
  // parameter checks
  if (COPY_CYC < 1 || COPY_CYC >= (1 << supply_ctrl_pkg::COPY_W))
    $error("COPY_CYC out of range");
  if (RST_UNIT_CYC < 1 || RST_UNIT_CYC * 255 >= (1 << supply_ctrl_pkg::CNT_W))
    $error("RST_UNIT_CYC out of range");
  if (CTL_MIN_CYC < 1 || CTL_MIN_CYC >= (1 << supply_ctrl_pkg::CTL_W))
    $error("CTL_MIN_CYC out of range");

  supply_ctrl_pkg::ctrl_state_t s, n;

  logic [3:0]  tgt_mask;
  logic [3:0]  on_req;
  logic [3:0]  off_req;
  logic        en_ok;
  logic        en_fall;
  logic        ctl_rise;
  logic        ctl_fall;
  logic        glob;
  logic        up;
  logic        alert_set;
  logic        clr_faults;
  logic        ara_rd;
  logic        rst_done;
  logic [supply_ctrl_pkg::CNT_W-1:0] rst_tgt;

  // three-level pins to address: open weighs 1<<i, high weighs 1<<i plus 1<<(i+3)
  function automatic logic [6:0] pin_addr(input logic [2:0] hi,
                                          input logic [2:0] op);
    logic [6:0] a;
    a = 7'h00;
    for (int i = 0; i < 3; i++) begin
      if (op[i]) begin
        a[i] = 1'b1;
      end else if (hi[i]) begin
        a[i]     = 1'b1;
        a[i + 3] = 1'b1;
      end
    end
    if (a == 7'h00) begin
      a = supply_ctrl_pkg::ADDR_ALL_LOW;
    end
    return a;
  endfunction

  assign rst_tgt  = supply_ctrl_pkg::CNT_W'(s.rst_dly * RST_UNIT_CYC);
  assign rst_done = s.rst_cnt >= rst_tgt;

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    // pin conditioning: a change counts once stages 2 and 3 agree
    n.en_sync = {s.en_sync[1:0], en_pin_in};
    if (s.en_sync[2] == s.en_sync[1]) begin
      n.en_lvl = s.en_sync[2];
    end
    for (int i = 0; i < 3; i++) begin
      n.hi_sync[i] = {s.hi_sync[i][1:0], addr_pin_high_in[i]};
      n.op_sync[i] = {s.op_sync[i][1:0], addr_pin_open_in[i]};
      if (s.hi_sync[i][2] == s.hi_sync[i][1]) begin
        n.hi_lvl[i] = s.hi_sync[i][2];
      end
      if (s.op_sync[i][2] == s.op_sync[i][1]) begin
        n.op_lvl[i] = s.op_sync[i][2];
      end
    end

    // boot: latch pins, then copy stored configuration
    unique case (s.boot)
      supply_ctrl_pkg::B_SETTLE: begin
        n.copy_cnt = s.copy_cnt + 1'b1;
        if (s.copy_cnt == supply_ctrl_pkg::COPY_W'(
              supply_ctrl_pkg::SETTLE_CYC)) begin
          n.slave_addr = pin_addr(s.hi_lvl, s.op_lvl);
          n.ctl_state  = s.hi_lvl[2];
          n.copy_cnt   = '0;
          n.boot       = supply_ctrl_pkg::B_COPY;
        end
      end
      supply_ctrl_pkg::B_COPY: begin
        n.copy_cnt = s.copy_cnt + 1'b1;
        if (s.copy_cnt == supply_ctrl_pkg::COPY_W'(COPY_CYC - 1)) begin
          if (eeprom_in.valid && !eeprom_in.addr[7]) begin
            n.slave_addr = eeprom_in.addr[6:0];
          end
          n.pol  = eeprom_in.pol;
          n.boot = supply_ctrl_pkg::B_RUN;
        end
      end
      supply_ctrl_pkg::B_RUN: begin
      end
      default: begin
        n.boot = supply_ctrl_pkg::B_SETTLE;
      end
    endcase

    // control pin debounce; inert until the address is latched
    ctl_rise = 1'b0;
    ctl_fall = 1'b0;
    if (s.boot != supply_ctrl_pkg::B_SETTLE &&
        s.hi_lvl[2] != s.ctl_state) begin
      n.ctl_cnt = s.ctl_cnt + 1'b1;
      if (s.ctl_cnt == supply_ctrl_pkg::CTL_W'(CTL_MIN_CYC - 1)) begin
        n.ctl_state = s.hi_lvl[2];
        n.ctl_cnt   = '0;
        ctl_rise    = s.hi_lvl[2];
        ctl_fall    = !s.hi_lvl[2];
      end
    end else begin
      n.ctl_cnt = '0;
    end

    // register writes
    clr_faults = 1'b0;
    on_req     = 4'h0;
    off_req    = 4'h0;
    if (s.page == supply_ctrl_pkg::PAGE_ALL) begin
      tgt_mask = 4'hf;
    end else if (s.page < 8'h04) begin
      tgt_mask = 4'h1 << s.page[1:0];
    end else begin
      tgt_mask = 4'h0;
    end
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        supply_ctrl_pkg::OFS_RST_SEL:  n.rst_sel  = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_RST_DLY:  n.rst_dly  = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_OUT_MODE: n.out_mode = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_DEV_MODE: n.dev_mode = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_FRESP:    n.fresp    = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_ONOFF:    n.onoff    = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_PAGE:     n.page     = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_NEW_ADDR: n.new_addr = reg_req_in.wdata;
        supply_ctrl_pkg::OFS_CMD: begin
          if (reg_req_in.wdata[supply_ctrl_pkg::CMD_ON_BIT]) begin
            on_req = tgt_mask;
          end
          if (reg_req_in.wdata[supply_ctrl_pkg::CMD_OFF_BIT]) begin
            off_req = tgt_mask;
          end
          clr_faults = reg_req_in.wdata[supply_ctrl_pkg::CMD_CLR_BIT];
        end
        default: begin
        end
      endcase
    end
    if (s.onoff[supply_ctrl_pkg::ONOFF_CTL_BIT]) begin
      if (ctl_rise) begin
        on_req = 4'hf;
      end
      if (ctl_fall) begin
        off_req = 4'hf;
      end
    end

    // channel on state
    en_ok   = n.en_lvl || s.dev_mode[supply_ctrl_pkg::IGN_EN_BIT];
    en_fall = s.en_lvl && !n.en_lvl &&
              !s.dev_mode[supply_ctrl_pkg::IGN_EN_BIT] && (s.ch_on != 4'h0);
    if (en_fall && s.fresp[supply_ctrl_pkg::FRESP_OFF_BIT]) begin
      off_req = 4'hf;
    end
    n.ch_on = (s.ch_on | (on_req & {4{en_ok}})) & ~off_req & ~fault_in;

    // faults and alert; a new event wins over any clear
    n.fault_prev = fault_in;
    alert_set    = ((fault_in & ~s.fault_prev) != 4'h0) || en_fall;
    n.en_fault   = en_fall || (s.en_fault && !clr_faults);
    ara_rd       = reg_req_in.rd &&
                   (reg_req_in.addr == supply_ctrl_pkg::OFS_ARA);
    n.alert = alert_set || (s.alert && !(clr_faults || ara_rd ||
              (fault_in == 4'h0 && !s.en_fault)));
    // pull-low enable kept in its own flop so the pin sees no gate
    n.alert_oe_b = !n.alert;

    // reset output: counts only while the tied channel is good
    glob = (s.out_mode[supply_ctrl_pkg::GLOB_LSB +: 4] == 4'hf);
    up   = (s.rst_sel < 8'h04) && n.ch_on[s.rst_sel[1:0]] &&
           pgood_in[s.rst_sel[1:0]] &&
           (s.boot == supply_ctrl_pkg::B_RUN) &&
           !(glob && (fault_in != 4'h0));
    if (!up) begin
      n.rst_assert = 1'b1;
      n.rst_cnt    = '0;
    end else if (rst_done) begin
      n.rst_assert = 1'b0;
    end else begin
      n.rst_cnt = s.rst_cnt + 1'b1;
    end
    n.rst_oe_b = !n.rst_assert;

    // supply enables: low until polarity copied, then on xor polarity
    if (s.boot == supply_ctrl_pkg::B_RUN) begin
      n.sup_en = s.ch_on ^ s.pol;
    end else begin
      n.sup_en = 4'h0;
    end

    n.hit = (s.boot != supply_ctrl_pkg::B_SETTLE) &&
            (bus_addr_in == s.slave_addr ||
             bus_addr_in == supply_ctrl_pkg::ADDR_BCAST);
    n.pin_low = 1'b0;

    // read data stands only in the cycle after the strobe
    n.rdata = 8'h00;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        supply_ctrl_pkg::OFS_RST_SEL:  n.rdata = s.rst_sel;
        supply_ctrl_pkg::OFS_RST_DLY:  n.rdata = s.rst_dly;
        supply_ctrl_pkg::OFS_OUT_MODE: n.rdata = s.out_mode;
        supply_ctrl_pkg::OFS_DEV_MODE: n.rdata = s.dev_mode;
        supply_ctrl_pkg::OFS_FRESP:    n.rdata = s.fresp;
        supply_ctrl_pkg::OFS_ONOFF:    n.rdata = s.onoff;
        supply_ctrl_pkg::OFS_PAGE:     n.rdata = s.page;
        supply_ctrl_pkg::OFS_ARA:      n.rdata = {1'b0, s.slave_addr};
        supply_ctrl_pkg::OFS_STATUS:
          n.rdata = {s.alert, s.rst_assert, s.en_fault,
                     s.boot == supply_ctrl_pkg::B_RUN, s.ch_on};
        supply_ctrl_pkg::OFS_ADDR:     n.rdata = {1'b0, s.slave_addr};
        supply_ctrl_pkg::OFS_NEW_ADDR: n.rdata = s.new_addr;
        default:                       n.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s            <= '0;
      s.boot       <= supply_ctrl_pkg::B_SETTLE;
      s.rst_sel    <= supply_ctrl_pkg::RST_SEL_RST;
      s.rst_dly    <= supply_ctrl_pkg::RST_DLY_RST;
      s.out_mode   <= supply_ctrl_pkg::CFG_RST;
      s.page       <= supply_ctrl_pkg::CFG_RST;
      s.slave_addr <= supply_ctrl_pkg::ADDR_ALL_LOW;
      s.rst_assert <= 1'b1;
      s.alert_oe_b <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_out     = s.rdata;
  assign addr_hit_out      = s.hit;
  assign supply_enable_out = s.sup_en;
  assign reset_pin_out     = s.pin_low;
  assign reset_oe_b_out    = s.rst_oe_b;
  assign alert_pin_out     = s.pin_low;
  assign alert_oe_b_out    = s.alert_oe_b;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  property p_sel_bad;
    s.rst_sel > 8'h03 |=> s.rst_assert;
  endproperty
  a_sel_bad: assert property (p_sel_bad)
    else $error("reset released with invalid source");

  property p_off_reset;
    (s.rst_sel < 8'h04) && !s.ch_on[s.rst_sel[1:0]] |-> s.rst_assert;
  endproperty
  a_off_reset: assert property (p_off_reset)
    else $error("reset not asserted with tied channel off");

  property p_release;
    $fell(s.rst_assert) |-> $past(rst_done) && $past(up);
  endproperty
  a_release: assert property (p_release)
    else $error("reset released before timeout");

  property p_global;
    glob && (fault_in != 4'h0) |=> s.rst_assert;
  endproperty
  a_global: assert property (p_global)
    else $error("global fault did not assert reset");

  property p_alert_set;
    (fault_in & ~s.fault_prev) != 4'h0 |=> !alert_oe_b_out;
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("alert not raised on fault");

  property p_ara;
    ara_rd && !alert_set |=> alert_oe_b_out &&
      reg_rdata_out == {1'b0, s.slave_addr};
  endproperty
  a_ara: assert property (p_ara)
    else $error("alert response wrong");

  property p_clear;
    clr_faults && !alert_set |=> alert_oe_b_out ##1 s.en_fault == 1'b0 ||
      s.alert;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not release alert");

  property p_boot_low;
    s.boot != supply_ctrl_pkg::B_RUN |=> supply_enable_out == 4'h0 ||
      $past(s.boot) == supply_ctrl_pkg::B_RUN;
  endproperty
  a_boot_low: assert property (p_boot_low)
    else $error("enable driven before configuration copy");

  property p_pol;
    s.boot == supply_ctrl_pkg::B_RUN |=>
      supply_enable_out == ($past(s.ch_on) ^ $past(s.pol));
  endproperty
  a_pol: assert property (p_pol)
    else $error("enable polarity wrong");

  property p_en_block;
    !en_ok && (s.ch_on == 4'h0) |=> s.ch_on == 4'h0;
  endproperty
  a_en_block: assert property (p_en_block)
    else $error("supply turned on with enable low");

  property p_ctl_fall;
    ctl_fall && s.onoff[supply_ctrl_pkg::ONOFF_CTL_BIT] |=> s.ch_on == 4'h0;
  endproperty
  a_ctl_fall: assert property (p_ctl_fall)
    else $error("control fall did not turn supplies off");

  c_release: cover property ($fell(s.rst_assert));
  c_ara:     cover property (s.alert ##[1:20] ara_rd);
  c_ctl_on:  cover property (ctl_rise ##1 s.ch_on == 4'hf);

endmodule // supply_ctrl

// file: verification/board_model.sv
// board side model: supply good feedback and isolated control pin
`timescale 1ns/1ps
module board_model #(
  parameter int HIZ_CYC = 12
) (
  input  wire logic       clk_in,       // bench clock
  input  wire logic       rst_b_in,     // board reset, active low
  input  wire logic [3:0] en_act_in,    // supplies switched on
  input  wire logic       sys_en_in,    // system enable
  output logic [3:0]      pgood_out,    // supplies at target
  output logic [2:0]      pin_high_out, // address pins read high
  output logic [2:0]      pin_open_out  // address pins read open
);
  logic [4:0] hiz_reg;
  logic [3:0] ramp_reg;
  logic       hiz;
  // ==========================================================
  // straps: third pin isolated until latched, second low, first open
  assign hiz          = (hiz_reg < HIZ_CYC);
  assign pin_high_out = {sys_en_in & ~hiz, 2'b00};
  assign pin_open_out = {hiz, 2'b01};
  // ==========================================================
  // two-stage ramp so the reset timeout starts late, as on a board
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hiz_reg   <= 5'h00;
      ramp_reg  <= 4'h0;
      pgood_out <= 4'h0;
    end else begin
      if (hiz) begin
        hiz_reg <= hiz_reg + 5'h01;
      end
      ramp_reg  <= en_act_in;
      pgood_out <= ramp_reg & en_act_in;
    end
  end
endmodule // board_model

// file: verification/tb_supply_ctrl.sv
// self-checking bench for the supply control block
`timescale 1ns/1ps
module tb_supply_ctrl;
  localparam int CP     = 20;
  localparam int WD_CYC = 20000;
  logic                         mclk_in;
  logic                         rst_b_in;
  supply_ctrl_pkg::reg_req_t    req;
  supply_ctrl_pkg::eeprom_cfg_t ee;
  logic [7:0]                   rdata;
  logic [7:0]                   v;
  logic [3:0]                   pgood;
  logic [3:0]                   fault;
  logic [3:0]                   sup_en;
  logic [3:0]                   pol;
  logic [2:0]                   pin_hi;
  logic [2:0]                   pin_op;
  logic [6:0]                   bus_addr;
  logic                         en_pin;
  logic                         sys_en;
  logic                         hit;
  logic                         rst_pin;
  logic                         rst_oe_b;
  logic                         al_pin;
  logic                         al_oe_b;
  logic [6:0]                   ha [3];
  int                           num_errors;
  int                           total_checks;

  supply_ctrl #(.COPY_CYC(CP), .RST_UNIT_CYC(4), .CTL_MIN_CYC(3)) dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .pgood_in(pgood), .fault_in(fault),
    .en_pin_in(en_pin), .addr_pin_high_in(pin_hi),
    .addr_pin_open_in(pin_op), .eeprom_in(ee), .bus_addr_in(bus_addr),
    .addr_hit_out(hit), .supply_enable_out(sup_en),
    .reset_pin_out(rst_pin), .reset_oe_b_out(rst_oe_b),
    .alert_pin_out(al_pin), .alert_oe_b_out(al_oe_b));

  board_model board (
    .clk_in(mclk_in), .rst_b_in(rst_b_in), .en_act_in(sup_en ^ pol),
    .sys_en_in(sys_en), .pgood_out(pgood), .pin_high_out(pin_hi),
    .pin_open_out(pin_op));

  // ==========================================================
  // bus and check tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    req.wr <= 1'b0;
  endtask
  task cmd(input logic [7:0] d);
    wr(supply_ctrl_pkg::OFS_CMD, d);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // power cycle with a given stored configuration
  task boot(input logic ok, input logic [7:0] a, input logic [3:0] p);
    @(posedge mclk_in);
    ee <= '{ok, a, p};
    pol <= p;
    rst_b_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    cyc(CP);
    chk({7'h00, rst_oe_b}, 8'h00);
    chk({4'h0, sup_en}, 8'h00);
    cyc(12);
    chk({4'h0, sup_en}, {4'h0, p});
    chk({7'h00, al_oe_b}, 8'h01);
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    #(WD_CYC * 25);
    num_errors++;
    end_of_test();
  end

  // ==========================================================
  // tests
  initial begin
    req = '0;
    ee = '0;
    pol = 4'h0;
    fault = 4'h0;
    en_pin = 1'b1;
    sys_en = 1'b0;
    bus_addr = 7'h00;
    rst_b_in = 1'b0;
    num_errors = 0;
    total_checks = 0;
    ha = '{7'h05, 7'h00, 7'h06};
    boot(1'b0, 8'h00, 4'h0);
    chk({7'h00, rst_pin}, 8'h00);
    chk({7'h00, al_pin}, 8'h00);
    rdc(supply_ctrl_pkg::OFS_ADDR, 8'h05);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in) bus_addr <= ha[i];
      cyc(2);
      chk({7'h00, hit}, {7'h00, i < 2});
    end
    rdc(8'h3c, 8'h00);
    wr(supply_ctrl_pkg::OFS_NEW_ADDR, 8'h22);
    rdc(supply_ctrl_pkg::OFS_NEW_ADDR, 8'h22);
    rdc(supply_ctrl_pkg::OFS_ADDR, 8'h05);
    tend("address");
    wr(supply_ctrl_pkg::OFS_RST_DLY, 8'h02);
    wr(supply_ctrl_pkg::OFS_PAGE, 8'hff);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h0f);
    chk({7'h00, rst_oe_b}, 8'h00);
    cyc(20);
    chk({7'h00, rst_oe_b}, 8'h01);
    cmd(8'h02);
    #1;
    chk({7'h00, rst_oe_b}, 8'h00);
    wr(supply_ctrl_pkg::OFS_RST_SEL, 8'h04);
    cmd(8'h01);
    cyc(30);
    chk({7'h00, rst_oe_b}, 8'h00);
    tend("reset");
    wr(supply_ctrl_pkg::OFS_RST_SEL, 8'h00);
    wr(supply_ctrl_pkg::OFS_OUT_MODE, 8'h0f);
    cyc(30);
    chk({7'h00, rst_oe_b}, 8'h01);
    @(posedge mclk_in) fault <= 4'h4;
    cyc(3);
    chk({7'h00, rst_oe_b}, 8'h00);
    chk({7'h00, al_oe_b}, 8'h00);
    rdc(supply_ctrl_pkg::OFS_ARA, 8'h05);
    cyc(1);
    chk({7'h00, al_oe_b}, 8'h01);
    @(posedge mclk_in) fault <= 4'h6;
    cyc(3);
    chk({7'h00, al_oe_b}, 8'h00);
    cmd(8'h04);
    cyc(2);
    chk({7'h00, al_oe_b}, 8'h01);
    @(posedge mclk_in) fault <= 4'h8;
    cyc(3);
    chk({7'h00, al_oe_b}, 8'h00);
    @(posedge mclk_in) fault <= 4'h0;
    cyc(3);
    chk({7'h00, al_oe_b}, 8'h01);
    wr(supply_ctrl_pkg::OFS_OUT_MODE, 8'h00);
    cmd(8'h02);
    tend("fault");
    @(posedge mclk_in) en_pin <= 1'b0;
    cyc(8);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h00);
    wr(supply_ctrl_pkg::OFS_DEV_MODE, 8'h01);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h0f);
    cmd(8'h02);
    wr(supply_ctrl_pkg::OFS_DEV_MODE, 8'h00);
    @(posedge mclk_in) en_pin <= 1'b1;
    cyc(8);
    wr(supply_ctrl_pkg::OFS_FRESP, 8'h01);
    cmd(8'h01);
    @(posedge mclk_in) en_pin <= 1'b0;
    cyc(8);
    chk({4'h0, sup_en}, 8'h00);
    rd(supply_ctrl_pkg::OFS_STATUS, v);
    chk(v & 8'h20, 8'h20);
    @(posedge mclk_in) en_pin <= 1'b1;
    cyc(8);
    cmd(8'h04);
    tend("enable");
    wr(supply_ctrl_pkg::OFS_PAGE, 8'h01);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h02);
    wr(supply_ctrl_pkg::OFS_PAGE, 8'hff);
    cmd(8'h02);
    wr(supply_ctrl_pkg::OFS_ONOFF, 8'h01);
    @(posedge mclk_in) sys_en <= 1'b1;
    cyc(20);
    chk({4'h0, sup_en}, 8'h0f);
    @(posedge mclk_in) sys_en <= 1'b0;
    cyc(20);
    chk({4'h0, sup_en}, 8'h00);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h0f);
    tend("control");
    boot(1'b1, 8'h33, 4'h1);
    rdc(supply_ctrl_pkg::OFS_ADDR, 8'h33);
    wr(supply_ctrl_pkg::OFS_PAGE, 8'hff);
    cmd(8'h01);
    cyc(3);
    chk({4'h0, sup_en}, 8'h0e);
    boot(1'b1, 8'hb3, 4'h0);
    rdc(supply_ctrl_pkg::OFS_ADDR, 8'h05);
    tend("stored config");
    end_of_test();
  end
endmodule // tb_supply_ctrl
